// ---- rtl/srw_consts.svh ----
// Timing constants and counter width for the supervisor reset and watchdog core
`ifndef SRW_CONSTS_SVH
`define SRW_CONSTS_SVH

// Clock rate in Hz (25 ns period)
`define SRW_CLK_HZ        40000000
// Time base tick period in microseconds
`define SRW_TICK_US       1000
// Cycles per time base tick, derived from the rate
`define SRW_TICK_CYC      ((`SRW_CLK_HZ / 1000000) * `SRW_TICK_US)
// Reset timeout in ms, least figure
`define SRW_RST_TO_MS     140
// Long watchdog period in ms (35 s least)
`define SRW_WD_LONG_MS    35000
// Short watchdog period in ms (1.12 s least)
`define SRW_WD_SHORT_MS   1120
// Tick counts, rounded up from ms at one tick per ms
`define SRW_RST_TO_TICKS  ((`SRW_RST_TO_MS * 1000 + `SRW_TICK_US - 1) / `SRW_TICK_US)
`define SRW_WD_LONG_TICKS ((`SRW_WD_LONG_MS * 1000 + `SRW_TICK_US - 1) / `SRW_TICK_US)
`define SRW_WD_SHORT_TICKS ((`SRW_WD_SHORT_MS * 1000 + `SRW_TICK_US - 1) / `SRW_TICK_US)
// Counter width for all tick counters
`define SRW_CNT_W         20

`endif

// ---- rtl/srw_pkg.sv ----
// Types shared by the supervisor reset and watchdog core
package srw_pkg;
	// Watchdog period mode
	typedef enum logic [0:0] {
		SRW_WD_LONG  = 1'b0,
		SRW_WD_SHORT = 1'b1
	} srw_wd_mode_t;
endpackage

// ---- rtl/srw_hold_timer.sv ----
// Reset stretcher: holds a reset low for a tick count after its cause clears
`include "srw_consts.svh"
module srw_hold_timer
	import srw_pkg::*;
#(
	parameter int unsigned CNT_W = `SRW_CNT_W
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_cause,
	input  wire logic             i_tick,
	input  wire logic [CNT_W-1:0] i_hold_ticks,
	output logic                  o_reset_n
);
	// Ticks counted since the cause cleared
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	// Output register, low while in reset
	logic             rst_n_q;
	logic             rst_n_d;
	// Timeout reached
	wire              done = (cnt_q >= i_hold_ticks);

	// Cause restarts the count from zero
	assign cnt_d   = i_cause ? '0 : ((!done && i_tick) ? cnt_q + 1'b1 : cnt_q);
	assign rst_n_d = !i_cause && done;
	assign o_reset_n = rst_n_q;

	// Count and output flops; reset power-up holds the output low
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q   <= '0;
			rst_n_q <= 1'b0;
		end else begin
			cnt_q   <= cnt_d;
			rst_n_q <= rst_n_d;
		end
	end
endmodule

// ---- rtl/srw_supervisor.sv ----
// Supervisor core: reset combining, reset stretch, dual-period watchdog, power-fail
`include "srw_consts.svh"

module srw_supervisor
	import srw_pkg::*;
#(
	parameter int unsigned CNT_W      = `SRW_CNT_W,
	parameter int unsigned TICK_CYC   = `SRW_TICK_CYC,
	parameter int unsigned RST_TICKS  = `SRW_RST_TO_TICKS,
	parameter int unsigned LONG_TICKS = `SRW_WD_LONG_TICKS,
	parameter int unsigned SHORT_TICKS = `SRW_WD_SHORT_TICKS
) (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_primary_supply_low,
	input  wire logic i_secondary_supply_low,
	input  wire logic i_aux_undervoltage_in,
	input  wire logic i_power_fail_sense_in,
	input  wire logic i_manual_reset_n,
	input  wire logic i_watchdog_kick_in,
	output logic      o_primary_reset_n,
	output logic      o_secondary_reset_n,
	output logic      o_power_fail_out_n
);
	// Tick prescaler width
	localparam int unsigned PW = $clog2(TICK_CYC + 1);
	// Typed tick counts
	localparam logic [CNT_W-1:0] RST_T   = CNT_W'(RST_TICKS);
	localparam logic [CNT_W-1:0] LONG_T  = CNT_W'(LONG_TICKS);
	localparam logic [CNT_W-1:0] SHORT_T = CNT_W'(SHORT_TICKS);
	localparam logic [PW-1:0]    TICK_LAST = PW'(TICK_CYC - 1);

	// Time base prescaler and tick pulse
	logic [PW-1:0]    pre_q;
	logic             tick_q;
	// Watchdog state
	logic [CNT_W-1:0] wd_q;
	logic [CNT_W-1:0] wd_d;
	srw_wd_mode_t     mode_q;
	srw_wd_mode_t     mode_d;
	logic             kick_prev_q;
	logic             wd_fire_q;
	// Power-fail output register
	logic             pf_n_q;
	// Stretcher outputs
	logic             prim_n;
	logic             sec_n;

	// Cause decode
	wire supply_fault = i_primary_supply_low || i_secondary_supply_low;
	wire manual_req   = !i_manual_reset_n;
	// Secondary cause: supplies and manual only
	wire sec_cause    = supply_fault || manual_req;
	// Primary cause adds adjustable input and watchdog expiry
	wire prim_cause   = sec_cause || i_aux_undervoltage_in || wd_fire_q;
	// Kick edge either direction
	wire kick_edge    = i_watchdog_kick_in ^ kick_prev_q;
	// Reset currently asserted on the primary output or its cause
	wire any_reset    = prim_cause || !prim_n;
	// Active watchdog limit
	wire [CNT_W-1:0] wd_limit = (mode_q == SRW_WD_SHORT) ? SHORT_T : LONG_T;
	wire             wd_expire = (wd_q >= wd_limit);

	// Watchdog next state: cleared on reset or edge, counts ticks
	assign wd_d = (any_reset || kick_edge) ? '0 :
		((tick_q && !wd_expire) ? wd_q + 1'b1 : wd_q);

	// Mode: long after any reset event, short after first edge
	always_comb begin
		case (mode_q)
			SRW_WD_LONG:  mode_d = (!any_reset && kick_edge) ? SRW_WD_SHORT : SRW_WD_LONG;
			SRW_WD_SHORT: mode_d = any_reset ? SRW_WD_LONG : SRW_WD_SHORT;
			default:      mode_d = SRW_WD_LONG;
		endcase
	end

	// Free-running tick generator
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pre_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			pre_q  <= (pre_q == TICK_LAST) ? '0 : pre_q + 1'b1;
			tick_q <= (pre_q == TICK_LAST);
		end
	end

	// Watchdog counter, mode and expiry pulse
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wd_q        <= '0;
			mode_q      <= SRW_WD_LONG;
			kick_prev_q <= 1'b0;
			wd_fire_q   <= 1'b0;
		end else begin
			wd_q        <= wd_d;
			mode_q      <= mode_d;
			kick_prev_q <= i_watchdog_kick_in;
			wd_fire_q   <= wd_expire && !any_reset;
		end
	end

	// Power-fail output follows the comparator through one register, a cycle later, with no stretch
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pf_n_q <= 1'b0;
		end else begin
			pf_n_q <= !i_power_fail_sense_in;
		end
	end

	// Primary reset stretcher
	srw_hold_timer #(.CNT_W(CNT_W)) u_prim (
		.i_clk        (i_clk),
		.i_rst_n      (i_rst_n),
		.i_cause      (prim_cause),
		.i_tick       (tick_q),
		.i_hold_ticks (RST_T),
		.o_reset_n    (prim_n)
	);

	// Secondary reset stretcher
	srw_hold_timer #(.CNT_W(CNT_W)) u_sec (
		.i_clk        (i_clk),
		.i_rst_n      (i_rst_n),
		.i_cause      (sec_cause),
		.i_tick       (tick_q),
		.i_hold_ticks (RST_T),
		.o_reset_n    (sec_n)
	);

	// Reset outputs come straight from stretcher flops, power-fail from its own flop
	assign o_primary_reset_n   = prim_n;
	assign o_secondary_reset_n = sec_n;
	assign o_power_fail_out_n  = pf_n_q;

	// Helper: ticks since primary cause dropped, saturating so it never wraps
	logic [CNT_W-1:0] chk_ticks_q;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			chk_ticks_q <= '0;
		end else if (prim_cause) begin
			chk_ticks_q <= '0;
		end else if (chk_ticks_q < RST_T) begin
			chk_ticks_q <= chk_ticks_q + CNT_W'(tick_q);
		end
	end

	// Helper: ticks since secondary cause dropped, saturating likewise
	logic [CNT_W-1:0] chk_sec_ticks_q;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			chk_sec_ticks_q <= '0;
		end else if (sec_cause) begin
			chk_sec_ticks_q <= '0;
		end else if (chk_sec_ticks_q < RST_T) begin
			chk_sec_ticks_q <= chk_sec_ticks_q + CNT_W'(tick_q);
		end
	end

	// Secondary drops the cycle after its cause
	chk_sec_on_cause: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		sec_cause |=> !o_secondary_reset_n)
		else $error("secondary reset not low during cause");
	// Manual request pulls both outputs
	chk_manual_both: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		manual_req |=> (!o_primary_reset_n && !o_secondary_reset_n))
		else $error("manual reset did not force both resets");
	// Supply or adjustable fault pulls primary
	chk_prim_cause: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(supply_fault || i_aux_undervoltage_in) |=> !o_primary_reset_n)
		else $error("primary reset not low on fault");
	// Primary stays low until the timeout is counted
	chk_prim_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!prim_cause && chk_ticks_q < RST_T) |=> !o_primary_reset_n)
		else $error("primary reset released before timeout");
	// Primary lets go once the timeout is counted
	chk_prim_release: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!prim_cause && chk_ticks_q >= RST_T) |=> o_primary_reset_n)
		else $error("primary reset held past timeout");
	// Secondary does not release right as its cause clears
	chk_sec_release: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		$fell(sec_cause) |=> !o_secondary_reset_n [*2])
		else $error("secondary reset released without hold");
	// Secondary lets go once its own timeout is counted
	chk_sec_timeout_free: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!sec_cause && chk_sec_ticks_q >= RST_T) |=> o_secondary_reset_n)
		else $error("secondary reset held past timeout");
	// Kick edge or reset empties the watchdog
	chk_wd_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(kick_edge || any_reset) |=> (wd_q == '0))
		else $error("watchdog not cleared");
	// Limit reached outside reset raises the expiry pulse
	chk_wd_expiry: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(wd_expire && !any_reset) |=> wd_fire_q)
		else $error("watchdog limit reached without expiry");
	// Expiry pulse pulls primary
	chk_wd_fire: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		wd_fire_q |=> !o_primary_reset_n)
		else $error("watchdog expiry did not reset");
	// Any reset returns the watchdog to the long period
	chk_wd_mode: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		any_reset |=> (mode_q == SRW_WD_LONG))
		else $error("watchdog not long after reset");
	// First kick outside reset selects the short period
	chk_wd_short: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(mode_q == SRW_WD_LONG && kick_edge && !any_reset) |=> (mode_q == SRW_WD_SHORT))
		else $error("watchdog not short after first kick");
	// Power-fail output asserts with its comparator
	chk_pf_follow: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_power_fail_sense_in |=> !o_power_fail_out_n)
		else $error("power fail output not following");
	// Power-fail output releases with no stretch
	chk_pf_release: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!i_power_fail_sense_in |=> o_power_fail_out_n)
		else $error("power fail output not releasing");
	// A new cause empties the primary stretch counter
	chk_restart: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		prim_cause |=> (u_prim.cnt_q == '0))
		else $error("timeout not restarted");
endmodule

// ---- test/srw_host_model.sv ----
// Host processor model: takes the primary reset and toggles the watchdog input
module srw_host_model (
	input  wire logic       i_clk,
	input  wire logic       i_run,
	input  wire logic [7:0] i_period,
	input  wire logic       i_reset_n,
	output logic            o_kick
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_q  = 8'h00; // Cycles since last kick
	logic       kick_q = 1'b0;  // Kick level, one driver only
	assign o_kick = kick_q;
	// Kick once per period, silent while held in reset or stopped
	always @(negedge i_clk) begin
		if (!i_run || !i_reset_n) begin
			cnt_q <= 8'h00;
		end else if (cnt_q >= i_period) begin
			cnt_q  <= 8'h00;
			kick_q <= ~kick_q;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end
endmodule

// ---- test/srw_supervisor_tb.sv ----
// Self-checking bench for the supervisor core with a host model
module srw_supervisor_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TC = 4, RT = 5, LT = 20, ST = 8; // Short sim counts
	logic clk = 0, rst_n = 0, p_low = 0, s_low = 0, aux = 0, power_fail_sense_in = 0;
	logic mr_n = 1, run = 0;
	logic [7:0] per = 8'h05; // Host kick period
	wire kick, p_n, s_n, pf_n;
	int bad_count = 0, compares = 0, seed = 32'h969d;
	always #12.5 clk = ~clk;
	srw_supervisor #(.TICK_CYC(TC), .RST_TICKS(RT), .LONG_TICKS(LT), .SHORT_TICKS(ST))
	i_srw_supervisor (.i_clk(clk), .i_rst_n(rst_n), .i_primary_supply_low(p_low),
		.i_secondary_supply_low(s_low), .i_aux_undervoltage_in(aux),
		.i_power_fail_sense_in(power_fail_sense_in), .i_manual_reset_n(mr_n),
		.i_watchdog_kick_in(kick), .o_primary_reset_n(p_n),
		.o_secondary_reset_n(s_n), .o_power_fail_out_n(pf_n));
	srw_host_model i_srw_host_model (.i_clk(clk), .i_run(run), .i_period(per),
		.i_reset_n(p_n), .o_kick(kick));
	// One bit compare
	task chk(string nm, logic e, logic g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %b seen %b", nm, e, g);
		end
	endtask
	task cyc(int n);
		repeat (n) @(negedge clk);
	endtask
	task print_verdict();
		if (bad_count == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Bounds of the stretch after a cause clears
	function int hold_min();
		return (RT - 1) * TC;
	endfunction
	function int hold_max();
		return (RT + 1) * TC + 3;
	endfunction
	// Secondary reset follows supplies and manual only
	function logic sec_hit(int w);
		return w != 2;
	endfunction
	task set_cause(int w, logic v);
		case (w)
			0: p_low = v;
			1: s_low = v;
			2: aux = v;
			default: mr_n = ~v;
		endcase
	endtask
	task wait_rel();
		for (int i = 0; i < 300 && p_n !== 1'b1; i++) cyc(1);
		chk("p_n release", 1'b1, p_n);
	endtask
	// Watchdog against hangs
	initial begin
		#500us;
		bad_count++;
		print_verdict();
	end
	initial begin
		cyc(5);
		chk("p_n in reset", 1'b0, p_n);
		chk("s_n in reset", 1'b0, s_n);
		chk("pf_n in reset", 1'b0, pf_n);
		cyc(5);
		rst_n = 1;
		cyc(hold_min());
		chk("p_n after reset", 1'b0, p_n);
		chk("s_n after reset", 1'b0, s_n);
		wait_rel();
		// Each cause asserts, then stretches; host kicks at random
		for (int w = 0; w < 4; w++) begin
			per = 8'($unsigned($random(seed)) % 19 + 1);
			run = 1;
			set_cause(w, 1);
			cyc(2);
			chk("p_n cause", 1'b0, p_n);
			chk("s_n cause", ~sec_hit(w), s_n);
			set_cause(w, 0);
			cyc(3 * TC);
			set_cause(w, 1);
			cyc(1);
			set_cause(w, 0);
			cyc(hold_min());
			chk("p_n hold", 1'b0, p_n);
			chk("s_n hold", ~sec_hit(w), s_n);
			cyc(hold_max() - hold_min());
			chk("p_n free", 1'b1, p_n);
			chk("s_n free", 1'b1, s_n);
		end
		// Steady random kicks keep the watchdog quiet
		for (int i = 0; i < 300; i++) begin
			cyc(1);
			chk("p_n kicked", 1'b1, p_n);
		end
		// No kicks after a reset event: long period applies
		run = 0;
		set_cause(3, 1);
		cyc(2);
		set_cause(3, 0);
		wait_rel();
		cyc((LT - 1) * TC);
		chk("p_n long", 1'b1, p_n);
		cyc(2 * TC + 4);
		chk("p_n expire", 1'b0, p_n);
		chk("s_n expire", 1'b1, s_n);
		wait_rel();
		// One kick switches to the short period
		per = 8'h02;
		run = 1;
		cyc(4);
		run = 0;
		cyc((ST - 2) * TC);
		chk("p_n short", 1'b1, p_n);
		cyc(3 * TC + 4);
		chk("p_n short exp", 1'b0, p_n);
		// Power-fail output follows its comparator
		for (int i = 0; i < 20; i++) begin
			power_fail_sense_in = 1'($random(seed));
			cyc(2);
			chk("pf_n", ~power_fail_sense_in, pf_n);
		end
		// Reset again in mid-run: all outputs low, then a fresh stretch
		power_fail_sense_in = 0;
		rst_n = 0;
		cyc(2);
		chk("p_n mid reset", 1'b0, p_n);
		chk("s_n mid reset", 1'b0, s_n);
		chk("pf_n mid reset", 1'b0, pf_n);
		rst_n = 1;
		cyc(hold_min());
		chk("p_n after mid reset", 1'b0, p_n);
		chk("s_n after mid reset", 1'b0, s_n);
		wait_rel();
		chk("s_n mid released", 1'b1, s_n);
		print_verdict();
	end
endmodule
